// >>> include/ovlm_pkg.sv
// shared constants and types for the output voltage limit monitor
// assumes a single 125 MHz clock and the command decode done upstream
package ovlm_pkg;
    // command codes of the three limit registers
    localparam logic [7:0] CMD_OV_WARN = 8'h42;
    localparam logic [7:0] CMD_UV_WARN = 8'h43;
    localparam logic [7:0] CMD_UV_FAULT = 8'h44;
    // limit indices
    localparam int NUM_LIM = 3;
    localparam int LIM_OVW = 0;
    localparam int LIM_UVW = 1;
    localparam int LIM_UVF = 2;
    // relative format: this raw value means 100 percent
    localparam logic [15:0] REL_UNITY = 16'h0200;
    // percentages are kept in half-percent units, 100 % = 200
    localparam logic [7:0] PCT_SCALE = 8'hC8;
    // supported range and step per limit, half-percent units
    localparam logic [7:0] LIM_MIN [NUM_LIM] = '{8'hCE, 8'hA8, 8'h78};
    localparam logic [7:0] LIM_MAX [NUM_LIM] = '{8'hE8, 8'hC2, 8'hBE};
    localparam logic [7:0] LIM_STEP [NUM_LIM] = '{8'h02, 8'h02, 8'h05};
    localparam bit LIM_RND_UP [NUM_LIM] = '{1'b1, 1'b0, 1'b0};
    localparam logic [7:0] LIM_CMD [NUM_LIM] = '{CMD_OV_WARN, CMD_UV_WARN, CMD_UV_FAULT};
    // hardware percentage used until a valid stored value arrives
    localparam logic [7:0] LIM_DEF_PCT [NUM_LIM] = '{8'hDC, 8'hB4, 8'hA0};
    localparam logic [15:0] DEF_RAW = 16'h0000;
    // status bit positions
    localparam int SV_OVW_BIT = 6;
    localparam int SV_UVW_BIT = 5;
    localparam int SV_UVF_BIT = 4;
    localparam int CML_INV_DATA_BIT = 6;
    // undervoltage fault response field
    localparam int UVR_RESP_LSB = 6;
    localparam logic [1:0] UVR_IGNORE = 2'h0;
    localparam logic [1:0] UVR_DELAYED = 2'h1;
    localparam logic [1:0] UVR_NOW = 2'h2;
    // restart counter ceiling
    localparam logic [2:0] RESTART_MAX = 3'h7;
    // one host transaction, already decoded from the bus
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] code;
        logic [15:0] data;
    } ovlm_cmd_t;
    // status the block exposes
    typedef struct packed {
        logic [7:0] vout;
        logic [7:0] cml;
        logic word_vout;
        logic word_cml;
    } ovlm_status_t;
    // restart watch states
    typedef enum logic [0:0] {
        RS_IDLE = 1'b0,
        RS_WATCH = 1'b1
    } ovlm_rs_state_t;
endpackage : ovlm_pkg

// >>> hdl/ovlm_pct_map.sv
// maps a written limit word onto a supported hardware percentage
// assumes base is the present output target in absolute mode, else unity
`timescale 1ns/1ps
module ovlm_pct_map #(
    parameter logic [7:0] MIN_PCT = 8'h00,
    parameter logic [7:0] MAX_PCT = 8'h00,
    parameter logic [7:0] STEP_PCT = 8'h01,
    parameter bit RND_UP = 1'b0
) (
    input wire logic [15:0] value_in,
    input wire logic [15:0] base_in,
    output logic [7:0] pct_out,
    output logic valid_out
);
    import ovlm_pkg::*;

    logic [24:0] val_s; // value scaled to half-percent units
    logic [24:0] cand; // base times one candidate
    logic [7:0] p; // candidate percentage

    // scan every supported step; both roundings fall out of one loop
    always_comb
    begin
        // operands widened first so the product never wraps at 16 bits
        val_s = 25'(value_in) * 25'(PCT_SCALE);
        pct_out = MIN_PCT;
        valid_out = 1'b0;
        cand = '0;
        p = MIN_PCT;
        // in range only if min <= value <= max, a zero base is never valid
        if ((base_in != 16'h0000)
            && (val_s >= 25'(base_in) * 25'(MIN_PCT))
            && (val_s <= 25'(base_in) * 25'(MAX_PCT)))
        begin
            valid_out = 1'b1;
        end
        for (int i = 0; i <= 255; i++)
        begin
            p = 8'(MIN_PCT + 8'(i) * STEP_PCT);
            cand = 25'(base_in) * 25'(p);
            if ((int'(MIN_PCT) + i * int'(STEP_PCT)) <= int'(MAX_PCT))
            begin
                if (RND_UP)
                begin
                    // keep the lowest step at or above the value
                    if ((cand >= val_s) && (pct_out == MIN_PCT))
                    begin
                        if ((25'(base_in) * 25'(pct_out)) < val_s)
                        begin
                            pct_out = p;
                        end
                    end
                end
                else if (cand <= val_s)
                begin
                    // keep the highest step at or below the value
                    pct_out = p;
                end
            end
        end
    end
endmodule : ovlm_pct_map

// >>> hdl/ovlm_top.sv
// output voltage limit monitor: warning and undervoltage fault limits
// assumes command decode, sense sampling and nvm read happen on mclk_in
//
// What this block does
// - reject unsupported limit writes, flag and alert
// - clear restart count after clean rise window
// - 42h word limit for overvoltage warning
// - relative limit; absolute mode keeps stored value
// - overvoltage warning sets status and alerts
// - overvoltage warning spans 103-116 percent, 1% steps
// - overvoltage warning rounds up between steps
// - map written limit per output voltage format
// - 43h word limit for undervoltage warning
// - undervoltage warning sets status and alerts
// - undervoltage warning spans 84-97 percent, 1% steps
// - undervoltage warning rounds down between steps
// - 44h undervoltage fault triggers selected response
// - overvoltage warning word loads from nvm
// - undervoltage warning word loads from nvm
// - undervoltage fault word loads from nvm
// - undervoltage fault spans 60-95 percent, 2.5% steps
`timescale 1ns/1ps
module ovlm_top (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input ovlm_pkg::ovlm_cmd_t host_cmd_in,
    input wire logic vout_abs_mode_in,
    input wire logic [15:0] vout_cmd_in,
    input wire logic [15:0] vout_sense_in,
    input wire logic [15:0] nvm_ovw_in,
    input wire logic [15:0] nvm_uvw_in,
    input wire logic [15:0] nvm_uvf_in,
    input wire logic [7:0] uvf_resp_in,
    input wire logic clear_faults_in,
    input wire logic restart_start_in,
    input wire logic rise_done_in,
    input wire logic shutdown_fault_in,
    input wire logic [15:0] ton_rise_cyc_in,
    output logic [15:0] rd_data_out,
    output logic rd_valid_out,
    output ovlm_pkg::ovlm_status_t status_out,
    output logic alert_n_out,
    output logic uv_shutdown_out,
    output logic [2:0] restart_count_out
);
    import ovlm_pkg::*;

    // stored limit words as the host wrote them
    logic [15:0] raw_reg [NUM_LIM];
    // hardware percentage each limit maps to
    logic [7:0] pct_reg [NUM_LIM];
    // one after reset once nvm values were taken
    logic loaded_reg;
    // word fed to each mapper
    logic [15:0] map_val [NUM_LIM];
    // mapper results
    logic [7:0] map_pct [NUM_LIM];
    logic map_ok [NUM_LIM];
    // this write targets a given limit
    logic hit_wr [NUM_LIM];
    // nvm copy per limit
    logic [15:0] nvm_val [NUM_LIM];
    // base of the scale: target in absolute mode, unity otherwise
    logic [15:0] map_base;
    // any write rejected this cycle
    logic bad_wr;
    // compare terms
    logic [24:0] sense_s;
    logic [24:0] thr [NUM_LIM];
    logic ovw_cond;
    logic uvw_cond;
    logic uvf_cond;
    // status registers
    logic [7:0] sv_reg;
    logic [7:0] sv_next;
    logic [7:0] cml_reg;
    logic [7:0] cml_next;
    logic [7:0] sv_set;
    logic [7:0] cml_set;
    // read path
    logic [15:0] rd_next;
    logic rd_hit;
    // fault response
    logic [1:0] uvr_resp;
    // restart tracking
    ovlm_rs_state_t rs_state_reg;
    ovlm_rs_state_t rs_next;
    logic [15:0] rs_cnt_reg;

    assign nvm_val[LIM_OVW] = nvm_ovw_in;
    assign nvm_val[LIM_UVW] = nvm_uvw_in;
    assign nvm_val[LIM_UVF] = nvm_uvf_in;

    // relative format scales against fixed unity, absolute against target
    assign map_base = vout_abs_mode_in ? vout_cmd_in : REL_UNITY;

    // after reset the first cycle takes nvm, thereafter host writes
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            loaded_reg <= 1'b0;
        end
        else
        begin
            loaded_reg <= 1'b1;
        end
    end

    // one limit register, mapper and write check per entry
    generate
        for (genvar g = 0; g < NUM_LIM; g++)
        begin : g_lim
            // decode of the write; nvm load takes priority until done
            assign hit_wr[g] = host_cmd_in.wr && (host_cmd_in.code == LIM_CMD[g]);
            assign map_val[g] = loaded_reg ? host_cmd_in.data : nvm_val[g];

            // range, step and rounding are fixed per limit
            ovlm_pct_map #(
                .MIN_PCT(LIM_MIN[g]),
                .MAX_PCT(LIM_MAX[g]),
                .STEP_PCT(LIM_STEP[g]),
                .RND_UP(LIM_RND_UP[g])
            ) u_map (
                .value_in(map_val[g]),
                .base_in(map_base),
                .pct_out(map_pct[g]),
                .valid_out(map_ok[g])
            );

            // stored word changes only on an accepted write or the load;
            // a later target change never rewrites it
            always_ff @(posedge mclk_in or negedge resetn_in)
            begin
                if (!resetn_in)
                begin
                    raw_reg[g] <= DEF_RAW;
                    pct_reg[g] <= LIM_DEF_PCT[g];
                end
                else if (!loaded_reg)
                begin
                    // the stored word follows nvm even if unmapped
                    raw_reg[g] <= map_val[g];
                    if (map_ok[g])
                    begin
                        pct_reg[g] <= map_pct[g];
                    end
                end
                else if (hit_wr[g] && map_ok[g])
                begin
                    raw_reg[g] <= map_val[g];
                    pct_reg[g] <= map_pct[g];
                end
            end

            // threshold in half-percent scaled sense units
            assign thr[g] = 25'(vout_cmd_in) * 25'(pct_reg[g]);
        end
    endgenerate

    // a write to any limit with an unsupported value is refused
    always_comb
    begin
        bad_wr = 1'b0;
        for (int i = 0; i < NUM_LIM; i++)
        begin
            if (loaded_reg && hit_wr[i] && !map_ok[i])
            begin
                bad_wr = 1'b1;
            end
        end
    end

    // sensed output scaled to the same units as the thresholds
    assign sense_s = 25'(vout_sense_in) * 25'(PCT_SCALE);

    // comparisons against the present target
    assign ovw_cond = sense_s > thr[LIM_OVW];
    assign uvw_cond = sense_s < thr[LIM_UVW];
    assign uvf_cond = sense_s < thr[LIM_UVF];

    // collect the set terms of this cycle
    always_comb
    begin
        sv_set = 8'h00;
        cml_set = 8'h00;
        sv_set[SV_OVW_BIT] = ovw_cond;
        sv_set[SV_UVW_BIT] = uvw_cond;
        sv_set[SV_UVF_BIT] = uvf_cond;
        cml_set[CML_INV_DATA_BIT] = bad_wr;
    end

    // sticky status: a set in the clear cycle survives the clear
    always_comb
    begin
        sv_next = sv_reg;
        cml_next = cml_reg;
        if (clear_faults_in)
        begin
            sv_next = 8'h00;
            cml_next = 8'h00;
        end
        sv_next = sv_next | sv_set;
        cml_next = cml_next | cml_set;
    end

    // status flops; bits are held until the host clears them
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            sv_reg <= 8'h00;
            cml_reg <= 8'h00;
        end
        else
        begin
            sv_reg <= sv_next;
            cml_reg <= cml_next;
        end
    end

    // summary bits and alert are registered from the next status, on the same edge as the status flops
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            status_out <= '0;
            alert_n_out <= 1'b1;
        end
        else
        begin
            status_out.vout <= sv_next;
            status_out.cml <= cml_next;
            status_out.word_vout <= |sv_next;
            status_out.word_cml <= |cml_next;
            // alert stays low while anything is flagged
            alert_n_out <= ~(|sv_next | |cml_next);
        end
    end

    // undervoltage fault action; delay timing lives in the power stage,
    // so both shutdown codes raise the request here
    assign uvr_resp = uvf_resp_in[UVR_RESP_LSB +: 2];

    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            uv_shutdown_out <= 1'b0;
        end
        else if (clear_faults_in && !uvf_cond)
        begin
            uv_shutdown_out <= 1'b0;
        end
        else if (uvf_cond && ((uvr_resp == UVR_DELAYED) || (uvr_resp == UVR_NOW)))
        begin
            uv_shutdown_out <= 1'b1;
        end
    end

    // read of a limit returns the stored word, not the percentage
    always_comb
    begin
        rd_next = 16'h0000;
        rd_hit = 1'b0;
        for (int i = 0; i < NUM_LIM; i++)
        begin
            if (host_cmd_in.rd && (host_cmd_in.code == LIM_CMD[i]))
            begin
                rd_next = raw_reg[i];
                rd_hit = 1'b1;
            end
        end
    end

    // read answer registered, one cycle after the request
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rd_data_out <= 16'h0000;
            rd_valid_out <= 1'b0;
        end
        else
        begin
            rd_data_out <= rd_next;
            rd_valid_out <= rd_hit;
        end
    end

    // restart watch: after the rise completes, wait one rise time
    always_comb
    begin
        rs_next = rs_state_reg;
        unique case (rs_state_reg)
            RS_IDLE:
            begin
                if (rise_done_in)
                begin
                    rs_next = RS_WATCH;
                end
            end
            RS_WATCH:
            begin
                // a shutdown fault abandons the window
                if (shutdown_fault_in || (rs_cnt_reg >= ton_rise_cyc_in))
                begin
                    rs_next = RS_IDLE;
                end
            end
        endcase
    end

    // state flop of the restart watch
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rs_state_reg <= RS_IDLE;
        end
        else
        begin
            rs_state_reg <= rs_next;
        end
    end

    // window timer counts cycles spent watching
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rs_cnt_reg <= 16'h0000;
        end
        else if (rs_state_reg == RS_WATCH)
        begin
            rs_cnt_reg <= rs_cnt_reg + 16'h0001;
        end
        else
        begin
            rs_cnt_reg <= 16'h0000;
        end
    end

    // attempts count up; a clean window resets the count to zero
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            restart_count_out <= 3'h0;
        end
        else if ((rs_state_reg == RS_WATCH) && !shutdown_fault_in
                 && (rs_cnt_reg >= ton_rise_cyc_in))
        begin
            restart_count_out <= 3'h0;
        end
        else if (restart_start_in && (restart_count_out != RESTART_MAX))
        begin
            // saturates so an endless retry never wraps to zero
            restart_count_out <= restart_count_out + 3'h1;
        end
    end
endmodule : ovlm_top

// >>> testbench/ovlm_chk.sv
// concurrent checks on the limit monitor ports, bound into ovlm_top
// assumes one clock mclk_in and the active-low async resetn_in
`timescale 1ns/1ps
module ovlm_chk (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input ovlm_pkg::ovlm_cmd_t host_cmd_in,
    input wire logic [7:0] uvf_resp_in,
    input wire logic clear_faults_in,
    input wire logic shutdown_fault_in,
    input wire logic rd_valid_out,
    input ovlm_pkg::ovlm_status_t status_out,
    input wire logic alert_n_out,
    input wire logic uv_shutdown_out,
    input wire logic [2:0] restart_count_out
);
    import ovlm_pkg::*;
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!resetn_in);
    // request names one of the three limit words
    logic hit;
    assign hit = (host_cmd_in.code == CMD_OV_WARN) || (host_cmd_in.code == CMD_UV_WARN)
        || (host_cmd_in.code == CMD_UV_FAULT);
    a_rd_answers: assert property (host_cmd_in.rd && hit |=> rd_valid_out)
        else $error("read of a limit word not answered");
    a_rd_only_hit: assert property (rd_valid_out |-> $past(host_cmd_in.rd) && $past(hit))
        else $error("read answer without a limit read");
    a_inv_cause: assert property ($rose(status_out.cml[CML_INV_DATA_BIT]) |-> $past(host_cmd_in.wr))
        else $error("invalid data flag without a write");
    a_inv_alert: assert property (status_out.cml[CML_INV_DATA_BIT] |-> status_out.word_cml && !alert_n_out)
        else $error("invalid data not reported to host");
    a_ovw_report: assert property (status_out.vout[SV_OVW_BIT] |-> status_out.word_vout && !alert_n_out)
        else $error("high warning not reported");
    a_uvw_report: assert property (status_out.vout[SV_UVW_BIT] |-> status_out.word_vout && !alert_n_out)
        else $error("low warning not reported");
    a_ovw_sticky: assert property (status_out.vout[SV_OVW_BIT] && !clear_faults_in |=> status_out.vout[SV_OVW_BIT])
        else $error("high warning dropped without clear");
    a_uvw_sticky: assert property ((status_out.vout[SV_UVW_BIT] && !clear_faults_in) [*2] |=> status_out.vout[SV_UVW_BIT])
        else $error("low warning dropped without clear");
    a_uv_ignore: assert property ($rose(uv_shutdown_out) |-> $past(uvf_resp_in[7:UVR_RESP_LSB]) != UVR_IGNORE)
        else $error("shutdown raised under ignore response");
    a_restart_keep: assert property (shutdown_fault_in [*3] |=> restart_count_out >= $past(restart_count_out))
        else $error("restart count cleared during a fault");
    // main scenarios reached
    c_read: cover property (rd_valid_out);
    c_invalid: cover property ($rose(status_out.cml[CML_INV_DATA_BIT]));
    c_shutdown: cover property ($rose(uv_shutdown_out));
    c_restart_ok: cover property ($fell(restart_count_out != 3'h0));
endmodule : ovlm_chk

bind ovlm_top ovlm_chk chk (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .host_cmd_in(host_cmd_in),
    .uvf_resp_in(uvf_resp_in),
    .clear_faults_in(clear_faults_in),
    .shutdown_fault_in(shutdown_fault_in),
    .rd_valid_out(rd_valid_out),
    .status_out(status_out),
    .alert_n_out(alert_n_out),
    .uv_shutdown_out(uv_shutdown_out),
    .restart_count_out(restart_count_out)
);

// >>> testbench/ovlm_host_model.sv
// host model: issues decoded word reads and writes of the limit words
// assumes requests launch 1 ns after a rising edge of clk_in
`timescale 1ns/1ps
module ovlm_host_model (
    input wire logic clk_in,
    input wire logic rd_valid_in,
    input wire logic [15:0] rd_data_in,
    output ovlm_pkg::ovlm_cmd_t cmd_out
);
    import ovlm_pkg::*;
    // idle word is flipped after each transfer so stale data never looks valid
    initial cmd_out = '0;
    // one word write; the caller keeps the high warning above the fault limit
    task automatic wr(input logic [7:0] code, input logic [15:0] data);
    begin
        @(posedge clk_in);
        #1;
        cmd_out = '{wr: 1'b1, rd: 1'b0, code: code, data: data};
        @(posedge clk_in);
        #1;
        cmd_out = '{wr: 1'b0, rd: 1'b0, code: 8'h00, data: ~data};
    end
    endtask : wr
    // one word read; the answer stands in the cycle after the taking edge
    task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic valid);
    begin
        @(posedge clk_in);
        #1;
        cmd_out = '{wr: 1'b0, rd: 1'b1, code: code, data: ~cmd_out.data};
        @(posedge clk_in);
        #1;
        data = rd_data_in;
        valid = rd_valid_in;
        cmd_out = '{wr: 1'b0, rd: 1'b0, code: 8'h00, data: ~cmd_out.data};
    end
    endtask : rd
endmodule : ovlm_host_model

// >>> testbench/tb_top.sv
// self-checking bench: limit words, thresholds, invalid writes, restart
// assumes the host model drives host_cmd_in; inputs move 1 ns after the edge
`timescale 1ns/1ps
module tb_top;
    import ovlm_pkg::*;
    logic mclk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic abs_mode = 1'b0; // relative format first
    logic [15:0] vcmd = 16'h03E8; // target of 1000 units
    logic [15:0] sense = 16'h03E8; // output on target
    logic [7:0] uvf_resp = 8'h80; // immediate shutdown
    logic clear_f = 1'b0;
    logic rs_start = 1'b0;
    logic rise_done = 1'b0;
    logic sd_fault = 1'b0;
    logic [15:0] ton = 16'h000A; // short rise time keeps the run brief
    logic [15:0] lim [NUM_LIM] = '{16'h0230, 16'h01C0, 16'h0180}; // expected stored words
    logic [15:0] bad [NUM_LIM] = '{16'h0300, 16'h0100, 16'h0000}; // 150, 50, 0 percent
    logic [7:0] resp [3] = '{8'h00, 8'h40, 8'h80};
    ovlm_cmd_t host_cmd;
    ovlm_status_t status;
    logic [15:0] rd_data;
    logic [15:0] got;
    logic rd_valid;
    logic gv;
    logic alert_n;
    logic uv_shut;
    logic [2:0] rs_cnt;
    int fails = 0;
    int num_checks = 0;
    always #4 mclk_in = ~mclk_in;
    ovlm_top uut (.mclk_in(mclk_in), .resetn_in(resetn_in), .host_cmd_in(host_cmd),
        .vout_abs_mode_in(abs_mode), .vout_cmd_in(vcmd), .vout_sense_in(sense),
        .nvm_ovw_in(16'h0230), .nvm_uvw_in(16'h01C0), .nvm_uvf_in(16'h0180),
        .uvf_resp_in(uvf_resp), .clear_faults_in(clear_f), .restart_start_in(rs_start),
        .rise_done_in(rise_done), .shutdown_fault_in(sd_fault), .ton_rise_cyc_in(ton),
        .rd_data_out(rd_data), .rd_valid_out(rd_valid), .status_out(status),
        .alert_n_out(alert_n), .uv_shutdown_out(uv_shut), .restart_count_out(rs_cnt));
    ovlm_host_model host (.clk_in(mclk_in), .rd_valid_in(rd_valid), .rd_data_in(rd_data), .cmd_out(host_cmd));
    task automatic cyc(input int n);
    begin
        repeat (n) @(posedge mclk_in);
        #1;
    end
    endtask : cyc
    task automatic chk_val(input logic [15:0] g, input logic [15:0] e, input string m);
    begin
        num_checks++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
        end
    end
    endtask : chk_val
    task automatic chk_bit(input logic g, input logic e, input string m);
    begin
        chk_val({15'h0000, g}, {15'h0000, e}, m);
    end
    endtask : chk_bit
    // status byte, summary bits and alert all follow from the expected flags
    task automatic flags(input logic [7:0] v, input logic c);
    begin
        chk_val({status.vout, status.cml}, {v, c ? 8'h40 : 8'h00}, "status");
        chk_bit(status.word_vout, |v, "word vout");
        chk_bit(status.word_cml, c, "word cml");
        chk_bit(alert_n, !((|v) || c), "alert");
    end
    endtask : flags
    task automatic rd_chk(input int i);
    begin
        host.rd(LIM_CMD[i], got, gv);
        chk_bit(gv, 1'b1, "read valid");
        chk_val(got, lim[i], "read data");
    end
    endtask : rd_chk
    // clear with the output back on target so nothing sets again
    task automatic clr;
    begin
        sense = vcmd;
        cyc(1);
        clear_f = 1'b1;
        cyc(1);
        clear_f = 1'b0;
        flags(8'h00, 1'b0);
    end
    endtask : clr
    task automatic set_sense(input logic [15:0] s);
    begin
        sense = s;
        cyc(2);
    end
    endtask : set_sense
    task automatic test_done;
    begin
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask : test_done
    initial
    begin
        #100000;
        fails++;
        $display("ERROR %0t watchdog expired", $time);
        test_done();
    end
    initial
    begin
        cyc(4);
        resetn_in = 1'b1;
        flags(8'h00, 1'b0);
        cyc(2);
        for (int i = 0; i < NUM_LIM; i++) rd_chk(i);
        $display("test reset done");
        lim = '{16'h0214, 16'h01C3, 16'h0180}; // 103.9, 88.1, 75 percent
        for (int i = 0; i < NUM_LIM; i++) host.wr(LIM_CMD[i], lim[i]);
        for (int i = 0; i < NUM_LIM; i++) rd_chk(i);
        host.rd(8'h45, got, gv);
        chk_bit(gv, 1'b0, "foreign code");
        chk_val(got, 16'h0000, "foreign data");
        for (int i = 0; i < NUM_LIM; i++)
        begin
            host.wr(LIM_CMD[i], bad[i]);
            flags(8'h00, 1'b1);
            rd_chk(i);
            clr();
        end
        $display("test write done");
        set_sense(16'h0410);
        flags(8'h00, 1'b0);
        set_sense(16'h0411);
        flags(8'h40, 1'b0);
        set_sense(16'h03E8);
        flags(8'h40, 1'b0);
        clr();
        set_sense(16'h0370);
        flags(8'h00, 1'b0);
        set_sense(16'h036F);
        flags(8'h20, 1'b0);
        set_sense(16'h02EE);
        chk_bit(uv_shut, 1'b0, "uv at limit");
        clr();
        for (int i = 0; i < 3; i++)
        begin
            uvf_resp = resp[i];
            set_sense(16'h02ED);
            chk_bit(uv_shut, i != 0, "uv response");
            flags(8'h30, 1'b0);
            clr();
            chk_bit(uv_shut, 1'b0, "uv released");
        end
        $display("test monitor done");
        abs_mode = 1'b1;
        lim[0] = 16'h044C; // 1100 of 1000 is 110 percent
        host.wr(CMD_OV_WARN, lim[0]);
        vcmd = 16'h07D0;
        set_sense(16'h0898);
        rd_chk(0);
        flags(8'h00, 1'b0);
        set_sense(16'h0899);
        flags(8'h40, 1'b0);
        clr();
        $display("test absolute done");
        for (int i = 0; i < 2; i++)
        begin
            rs_start = 1'b1;
            cyc(1);
            rs_start = 1'b0;
            cyc(1);
        end
        chk_val({13'h0000, rs_cnt}, 16'h0002, "restart count");
        rise_done = 1'b1;
        cyc(1);
        rise_done = 1'b0;
        cyc(5);
        chk_val({13'h0000, rs_cnt}, 16'h0002, "window open");
        cyc(10);
        chk_val({13'h0000, rs_cnt}, 16'h0000, "restart ok");
        sd_fault = 1'b1;
        rs_start = 1'b1;
        cyc(1);
        rs_start = 1'b0;
        rise_done = 1'b1;
        cyc(1);
        rise_done = 1'b0;
        cyc(15);
        chk_val({13'h0000, rs_cnt}, 16'h0001, "restart failed");
        sd_fault = 1'b0;
        $display("test restart done");
        test_done();
    end
endmodule : tb_top
